/* common/mri_pkg.sv */
// Package for the memory reference instruction unit: codes, fields, register map
package mri_pkg;
  // ----------------------------------------------------------------
  // Word and address widths
  // ----------------------------------------------------------------
  localparam int MRI_DW = 16; // Data word width
  localparam int MRI_AW = 15; // Memory address width
  // Instruction fields
  localparam int MRI_IND_BIT = 15; // Direct/indirect select
  localparam int MRI_PAGE_BIT = 10; // Zero/current page select
  localparam int MRI_OFS_HI = 9; // Top bit of the in-page offset
  localparam int MRI_OP_HI = 14; // Opcode field top bit
  localparam int MRI_OP_LO = 11; // Opcode field bottom bit, also A/B select
  // ----------------------------------------------------------------
  // Opcodes in bits 14..11
  // ----------------------------------------------------------------
  localparam logic [3:0] MRI_OP_AND = 4'h2;
  localparam logic [3:0] MRI_OP_XOR = 4'h4;
  localparam logic [3:0] MRI_OP_IOR = 4'h6;
  localparam logic [3:0] MRI_OP_JSB = 4'h3;
  localparam logic [3:0] MRI_OP_JMP = 4'h5;
  localparam logic [3:0] MRI_OP_ISZ = 4'h7;
  // Upper three bits of the paired opcodes; bit 11 picks the accumulator
  localparam logic [2:0] MRI_GRP_ADD = 3'h4;
  localparam logic [2:0] MRI_GRP_CMP = 3'h5;
  localparam logic [2:0] MRI_GRP_LOAD = 3'h6;
  localparam logic [2:0] MRI_GRP_STORE = 3'h7;
  // Addresses that stand for the accumulators
  localparam logic [14:0] MRI_ACC_A_ADDR = 15'h0000;
  localparam logic [14:0] MRI_ACC_B_ADDR = 15'h0001;
  // Program counter steps
  localparam logic [14:0] MRI_STEP = 15'h0001;
  localparam logic [14:0] MRI_SKIP = 15'h0002;
  // ----------------------------------------------------------------
  // Register port map (word indices)
  // ----------------------------------------------------------------
  localparam logic [2:0] MRI_REG_CTRL = 3'h0;
  localparam logic [2:0] MRI_REG_STATUS = 3'h1;
  localparam logic [2:0] MRI_REG_ACC_A = 3'h2;
  localparam logic [2:0] MRI_REG_ACC_B = 3'h3;
  localparam logic [2:0] MRI_REG_PC = 3'h4;
  localparam int MRI_CTRL_RUN = 0; // Run enable
  localparam int MRI_CTRL_CLR_EXT = 1; // Write one clears carry link
  localparam int MRI_CTRL_CLR_OVF = 2; // Write one clears overflow
  localparam int MRI_STAT_EXT = 0;
  localparam int MRI_STAT_OVF = 1;
  localparam int MRI_STAT_FETCH = 2; // Sequencer sits in the fetch phase
  localparam logic [15:0] MRI_RST_WORD = 16'h0000;
  localparam logic [14:0] MRI_RST_ADDR = 15'h0000;
  // Sequencer phases
  typedef enum logic [6:0] {
    MRI_ST_FETCH = 7'h01,
    MRI_ST_DECODE = 7'h02,
    MRI_ST_IND_RD = 7'h04,
    MRI_ST_IND_CAP = 7'h08,
    MRI_ST_OPER = 7'h10,
    MRI_ST_EXEC = 7'h20,
    MRI_ST_WRITE = 7'h40
  } mri_state_t;
endpackage : mri_pkg

/* hdl/mri_unit.sv */
// Memory reference instruction unit: sequencer, accumulators, register port
//
// Summary of operation
// - Offset bits 0-9, page bits from counter
// - Bit 10 picks page zero or current page
// - Zero means page zero, one current page
// - Addresses 0 and 1 are the accumulators
// - Bits 14-11 select fourteen operations
// - Two phases minimum, plain jump one
// - Logic ops combine bitwise into first accumulator
// - Subroutine jump stores return, continues X+1
// - Jump loads counter and address register
// - Increment, write back, skip on zero
// - Increment-skip never touches link or overflow
// - Add into selected accumulator, memory unchanged
// - Carry out sets link, sticky
// - Signed overflow sets sticky overflow bit
// - Compare full word, skip if different
// - Second compare uses second accumulator
// - Load replaces selected accumulator
// - Store writes accumulator, accumulator unchanged
// - Bit 15 selects direct or indirect
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module mri_unit
  import mri_pkg::*;
(
  input wire logic core_clk_i, // 100 MHz
  input wire logic sys_rst_i, // Synchronous, active high
  input wire logic preset_i, // Front panel preset, asynchronous pin
  output logic [mri_pkg::MRI_AW-1:0] mem_addr_o, // Memory address register
  output logic mem_rd_o, // Read strobe, data next cycle
  output logic mem_wr_o, // Write strobe
  output logic [mri_pkg::MRI_DW-1:0] mem_wdata_o, // Write data
  input wire logic [mri_pkg::MRI_DW-1:0] mem_rdata_i, // Read data
  input wire logic [2:0] reg_addr_i, // Register index
  input wire logic [mri_pkg::MRI_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [mri_pkg::MRI_DW-1:0] reg_rdata_o // Valid one cycle after read
);
  import mri_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mri_state_t state; // Current phase
  logic [MRI_AW-1:0] pc; // Program counter
  logic [MRI_AW-1:0] m; // Memory address register
  logic [MRI_DW-1:0] ir; // Instruction word
  logic [MRI_DW-1:0] acc_a; // First accumulator
  logic [MRI_DW-1:0] acc_b; // Second accumulator
  logic extend; // Carry link
  logic overflow; // Sticky overflow
  logic run; // Software run enable
  logic preset_meta; // First synchroniser stage
  logic preset_sync; // Second synchroniser stage

  // Word at address m: an accumulator or what memory returned
  function automatic logic [MRI_DW-1:0] mri_word(input logic [MRI_AW-1:0] a,
      input logic [MRI_DW-1:0] ra, input logic [MRI_DW-1:0] rb,
      input logic [MRI_DW-1:0] md);
    if (a == MRI_ACC_A_ADDR) begin
      return ra;
    end else if (a == MRI_ACC_B_ADDR) begin
      return rb;
    end
    return md;
  endfunction : mri_word

  // Operand address from an instruction word and the current page
  function automatic logic [MRI_AW-1:0] mri_ea(input logic [MRI_DW-1:0] w,
      input logic [MRI_AW-1:0] p);
    return {w[MRI_PAGE_BIT] ? p[MRI_OP_HI:MRI_PAGE_BIT] : 5'h00, w[MRI_OFS_HI:0]};
  endfunction : mri_ea

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  logic [3:0] op; // Opcode of the held instruction
  logic [3:0] dec_op; // Opcode of the word just fetched
  logic is_acc; // m points at an accumulator
  logic sel_b; // Paired opcode targets the second accumulator
  logic [MRI_DW-1:0] opnd; // Operand word in the execute phase
  logic [MRI_DW-1:0] sel_acc; // Accumulator named by the paired opcode
  logic [MRI_DW:0] sum; // Add result with carry
  logic [MRI_DW-1:0] inc; // Increment result
  logic [MRI_AW-1:0] dec_ea; // Operand address during decode
  logic [MRI_AW-1:0] pc_next; // Counter after execute
  logic skip; // Execute phase skips the next instruction
  logic needs_read; // Operation reads its operand
  logic mem_write; // Execute phase ends in a memory write

  assign op = ir[MRI_OP_HI:MRI_OP_LO];
  assign dec_op = mem_rdata_i[MRI_OP_HI:MRI_OP_LO];
  assign is_acc = (m == MRI_ACC_A_ADDR) || (m == MRI_ACC_B_ADDR);
  assign sel_b = ir[MRI_OP_LO];
  assign opnd = mri_word(m, acc_a, acc_b, mem_rdata_i);
  assign sel_acc = sel_b ? acc_b : acc_a;
  assign sum = {1'b0, sel_acc} + {1'b0, opnd};
  assign inc = opnd + MRI_RST_WORD + 16'h0001;
  assign dec_ea = mri_ea(mem_rdata_i, pc);
  // Store and subroutine jump never look at the old contents
  assign needs_read = (op[3:1] != MRI_GRP_STORE) && (op != MRI_OP_JSB);
  assign skip = ((op == MRI_OP_ISZ) && (inc == MRI_RST_WORD)) ||
      ((op[3:1] == MRI_GRP_CMP) && (opnd != sel_acc));
  assign pc_next = (op == MRI_OP_JSB) ? m + MRI_STEP :
      pc + (skip ? MRI_SKIP : MRI_STEP);
  assign mem_write = !is_acc && ((op[3:1] == MRI_GRP_STORE) || (op == MRI_OP_JSB) ||
      (op == MRI_OP_ISZ));

  // Strobes are decoded from the phase; operand accesses to accumulator addresses never touch memory, but a fetch from 0 or 1 does
  assign mem_addr_o = m;
  assign mem_rd_o = (state == MRI_ST_FETCH && run && !preset_sync) ||
      (state == MRI_ST_IND_RD && !is_acc) ||
      (state == MRI_ST_OPER && !is_acc && needs_read);
  assign mem_wr_o = (state == MRI_ST_WRITE);

  // ----------------------------------------------------------------
  // Preset pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      preset_meta <= 1'b0;
      preset_sync <= 1'b0;
    end else begin
      preset_meta <= preset_i;
      preset_sync <= preset_meta;
    end
  end

  // ----------------------------------------------------------------
  // Phase sequencer, program counter and address register
  // ----------------------------------------------------------------
  // Software may load P and M only while halted in fetch, so the
  // sequencer never sees a counter changed under it mid-instruction.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state <= MRI_ST_FETCH;
      pc <= MRI_RST_ADDR;
      m <= MRI_RST_ADDR;
      ir <= MRI_RST_WORD;
    end else if (preset_sync) begin
      // Preset drops an instruction not yet past execute and restarts at fetch; one in its write phase still writes
      state <= MRI_ST_FETCH;
      m <= pc;
    end else begin
      unique case (state)
        MRI_ST_FETCH: begin
          if (run) begin
            state <= MRI_ST_DECODE;
          end else if (reg_wr_i && reg_addr_i == MRI_REG_PC) begin
            pc <= reg_wdata_i[MRI_AW-1:0];
            m <= reg_wdata_i[MRI_AW-1:0];
          end
        end
        MRI_ST_DECODE: begin
          ir <= mem_rdata_i;
          m <= dec_ea;
          if (mem_rdata_i[MRI_IND_BIT]) begin
            state <= MRI_ST_IND_RD;
          end else if (dec_op == MRI_OP_JMP) begin
            pc <= dec_ea;
            state <= MRI_ST_FETCH;
          end else begin
            state <= MRI_ST_OPER;
          end
        end
        MRI_ST_IND_RD: begin
          state <= MRI_ST_IND_CAP;
        end
        MRI_ST_IND_CAP: begin
          // The fetched word is a full 15-bit address
          m <= opnd[MRI_AW-1:0];
          if (opnd[MRI_IND_BIT]) begin
            state <= MRI_ST_IND_RD;
          end else if (op == MRI_OP_JMP) begin
            pc <= opnd[MRI_AW-1:0];
            state <= MRI_ST_FETCH;
          end else begin
            state <= MRI_ST_OPER;
          end
        end
        MRI_ST_OPER: begin
          state <= MRI_ST_EXEC;
        end
        MRI_ST_EXEC: begin
          pc <= pc_next;
          if (mem_write) begin
            // Keep m on the target until the write phase is done
            state <= MRI_ST_WRITE;
          end else begin
            m <= pc_next;
            state <= MRI_ST_FETCH;
          end
        end
        MRI_ST_WRITE: begin
          m <= pc;
          state <= MRI_ST_FETCH;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write data for memory targets
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mem_wdata_o <= MRI_RST_WORD;
    end else if (state == MRI_ST_EXEC) begin
      if (op == MRI_OP_JSB) begin
        mem_wdata_o <= {1'b0, pc + MRI_STEP};
      end else if (op == MRI_OP_ISZ) begin
        mem_wdata_o <= inc;
      end else begin
        mem_wdata_o <= sel_acc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulators
  // ----------------------------------------------------------------
  // Execute-phase results take priority over a software load.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      acc_a <= MRI_RST_WORD;
      acc_b <= MRI_RST_WORD;
    end else if (state == MRI_ST_EXEC && !preset_sync) begin
      if (op == MRI_OP_AND) begin
        acc_a <= acc_a & opnd;
      end else if (op == MRI_OP_XOR) begin
        acc_a <= acc_a ^ opnd;
      end else if (op == MRI_OP_IOR) begin
        acc_a <= acc_a | opnd;
      end else if (op == MRI_OP_JSB && is_acc) begin
        // Return address lands in the accumulator that X names
        if (m[0]) acc_b <= {1'b0, pc + MRI_STEP};
        else acc_a <= {1'b0, pc + MRI_STEP};
      end else if (op == MRI_OP_ISZ && is_acc) begin
        if (m[0]) acc_b <= inc;
        else acc_a <= inc;
      end else if (op[3:1] == MRI_GRP_ADD) begin
        if (sel_b) acc_b <= sum[MRI_DW-1:0];
        else acc_a <= sum[MRI_DW-1:0];
      end else if (op[3:1] == MRI_GRP_LOAD) begin
        if (sel_b) acc_b <= opnd;
        else acc_a <= opnd;
      end else if (op[3:1] == MRI_GRP_STORE && is_acc) begin
        if (m[0]) acc_b <= sel_acc;
        else acc_a <= sel_acc;
      end
    end else if (reg_wr_i && reg_addr_i == MRI_REG_ACC_A) begin
      acc_a <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == MRI_REG_ACC_B) begin
      acc_b <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Link and overflow: sticky, set wins over a software clear
  // ----------------------------------------------------------------
  logic add_now; // Add executes this cycle
  assign add_now = (state == MRI_ST_EXEC) && !preset_sync && (op[3:1] == MRI_GRP_ADD);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      extend <= 1'b0;
      overflow <= 1'b0;
    end else begin
      if (add_now && sum[MRI_DW]) begin
        extend <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == MRI_REG_CTRL && reg_wdata_i[MRI_CTRL_CLR_EXT]) begin
        extend <= 1'b0;
      end
      if (add_now && (sel_acc[MRI_DW-1] == opnd[MRI_DW-1]) &&
          (sum[MRI_DW-1] != opnd[MRI_DW-1])) begin
        overflow <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == MRI_REG_CTRL && reg_wdata_i[MRI_CTRL_CLR_OVF]) begin
        overflow <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      run <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == MRI_REG_CTRL) begin
      run <= reg_wdata_i[MRI_CTRL_RUN];
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !reg_rd_i) begin
      reg_rdata_o <= MRI_RST_WORD;
    end else begin
      unique case (reg_addr_i)
        MRI_REG_CTRL: reg_rdata_o <= {15'h0000, run};
        MRI_REG_STATUS: reg_rdata_o <= {13'h0000, state == MRI_ST_FETCH, overflow, extend};
        MRI_REG_ACC_A: reg_rdata_o <= acc_a;
        MRI_REG_ACC_B: reg_rdata_o <= acc_b;
        MRI_REG_PC: reg_rdata_o <= {1'b0, pc};
        default: reg_rdata_o <= MRI_RST_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i || preset_sync);

  logic dec_direct; // Direct instruction in decode
  assign dec_direct = (state == MRI_ST_DECODE) && !mem_rdata_i[MRI_IND_BIT];

  property p_jmp_one; // Direct jump is back in fetch at its target
    dec_direct && dec_op == MRI_OP_JMP |=> state == MRI_ST_FETCH && pc == $past(dec_ea) && m == pc;
  endproperty
  a_jmp_one: assert property (p_jmp_one) else $error("jump not one phase");

  property p_page_zero;
    dec_direct && !mem_rdata_i[MRI_PAGE_BIT] |=> m[MRI_OP_HI:MRI_PAGE_BIT] == 5'h00;
  endproperty
  a_page_zero: assert property (p_page_zero) else $error("page zero not forced");

  property p_cur_page;
    dec_direct && mem_rdata_i[MRI_PAGE_BIT] |=>
        m == {$past(pc[MRI_OP_HI:MRI_PAGE_BIT]), $past(mem_rdata_i[MRI_OFS_HI:0])};
  endproperty
  a_cur_page: assert property (p_cur_page) else $error("current page wrong");

  property p_two_phase; // Direct non-jump operations reach execute two cycles on
    dec_direct && dec_op != MRI_OP_JMP |=> state == MRI_ST_OPER ##1 state == MRI_ST_EXEC;
  endproperty
  a_two_phase: assert property (p_two_phase) else $error("operand phase missing");

  property p_indirect;
    state == MRI_ST_IND_CAP && opnd[MRI_IND_BIT] |=> state == MRI_ST_IND_RD ##1 state == MRI_ST_IND_CAP;
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect chain broken");

  property p_load;
    state == MRI_ST_EXEC && op[3:1] == MRI_GRP_LOAD && !sel_b |=> acc_a == $past(opnd);
  endproperty
  a_load: assert property (p_load) else $error("load wrong");

  property p_cmp_skip;
    state == MRI_ST_EXEC && op[3:1] == MRI_GRP_CMP |=>
        pc == $past(pc) + (($past(opnd) != $past(sel_acc)) ? MRI_SKIP : MRI_STEP);
  endproperty
  a_cmp_skip: assert property (p_cmp_skip) else $error("compare skip wrong");

  property p_isz_flags;
    state == MRI_ST_EXEC && op == MRI_OP_ISZ && !reg_wr_i |=> $stable(extend) && $stable(overflow);
  endproperty
  a_isz_flags: assert property (p_isz_flags) else $error("increment touched flags");

  sequence s_store_write;
    state == MRI_ST_WRITE && mem_wr_o ##1 state == MRI_ST_FETCH && m == pc;
  endsequence
  property p_store;
    state == MRI_ST_EXEC && op[3:1] == MRI_GRP_STORE && !is_acc |=>
        mem_wdata_o == $past(sel_acc) && mem_addr_o == $past(m) ##0 s_store_write;
  endproperty
  a_store: assert property (p_store) else $error("store write wrong");

  property p_jsb;
    state == MRI_ST_EXEC && op == MRI_OP_JSB |=> pc == $past(m) + MRI_STEP;
  endproperty
  a_jsb: assert property (p_jsb) else $error("subroutine target wrong");

  property p_carry;
    add_now && sum[MRI_DW] |=> extend;
  endproperty
  a_carry: assert property (p_carry) else $error("carry not latched");
endmodule : mri_unit
`default_nettype wire

/* tb/mri_mem_model.sv */
// Behavioural core memory on the far side of the instruction unit
`timescale 1ns/10ps
`default_nettype none
module mri_mem_model
  import mri_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [mri_pkg::MRI_AW-1:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [mri_pkg::MRI_DW-1:0] mem_wdata_i,
  output logic [mri_pkg::MRI_DW-1:0] mem_rdata_o
);
  // ------------------------------------------------------------
  // Storage, preloaded by the bench
  // ------------------------------------------------------------
  logic [MRI_DW-1:0] mem [0:(1<<MRI_AW)-1]; // Whole address space
  // Data stand only in the cycle after the strobe; otherwise they flip,
  // so a sample taken a cycle late never matches by chance
  always @(posedge core_clk_i) begin
    if (mem_rd_i) begin
      mem_rdata_o <= mem[mem_addr_i];
    end else begin
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
  // Writes land at the strobe edge
  always @(posedge core_clk_i) begin
    if (mem_wr_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
  end
endmodule : mri_mem_model
`default_nettype wire

/* tb/memory_reference_instruction_unit_test.sv */
// Self-checking bench for the memory reference instruction unit
`timescale 1ns/10ps
`default_nettype none
module memory_reference_instruction_unit_test;
  import mri_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic preset_i = 1'b0; // Panel preset left idle
  logic [MRI_AW-1:0] mem_addr;
  logic mem_rd;
  logic mem_wr;
  logic [MRI_DW-1:0] mem_wdata;
  logic [MRI_DW-1:0] mem_rdata;
  logic [2:0] reg_addr = 3'h0;
  logic [MRI_DW-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [MRI_DW-1:0] reg_rdata;
  logic [MRI_DW-1:0] rd_val; // Last register read
  int error_cnt = 0;
  int n_compared = 0;
  // Clock at 100 MHz
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  mri_unit mri_unit_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .preset_i(preset_i),
    .mem_addr_o(mem_addr), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata),
    .mem_rdata_i(mem_rdata), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
  mri_mem_model mri_mem_model_inst (.core_clk_i(core_clk_i), .mem_addr_i(mem_addr),
    .mem_rd_i(mem_rd), .mem_wr_i(mem_wr), .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
  endtask : reg_write
  // Data are taken in the one cycle after the strobe
  task automatic reg_read(input logic [2:0] a);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk_i);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : reg_read
  task automatic mm(input logic [14:0] a, input logic [15:0] d);
    mri_mem_model_inst.mem[a] = d;
  endtask : mm
  function automatic logic [15:0] ins(input logic ind, input logic [3:0] op, input logic cur,
                                      input logic [9:0] ofs);
    return {ind, op, cur, ofs};
  endfunction : ins
  // Start at one address, wait for the closing self-jump, then halt
  task automatic run_prog(input logic [14:0] start, input logic [14:0] stop);
    int n;
    n = 0;
    reg_write(MRI_REG_CTRL, 16'h0006); // Halted, link and overflow cleared
    reg_write(MRI_REG_PC, {1'b0, start});
    reg_write(MRI_REG_CTRL, 16'h0001);
    while (!(mem_rd === 1'b1 && mem_addr === stop) && n < 400) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    chk("final fetch", {1'b0, mem_addr}, {1'b0, stop});
    // A plain jump to itself is back in fetch two cycles later
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("jump refetch", {mem_rd, mem_addr}, {1'b1, stop});
    reg_write(MRI_REG_CTRL, 16'h0000);
    repeat (6) reg_read(MRI_REG_STATUS);
    reg_read(MRI_REG_PC);
    chk("counter", rd_val, {1'b0, stop});
  endtask : run_prog
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Logic ops, load and store on page one, both page choices
  task automatic test_logic();
    mm(15'h0500, 16'h3355);
    mm(15'h0501, 16'hFFFF);
    mm(15'h0020, 16'h0F0F);
    mm(15'h0021, 16'h0001);
    mm(15'h0400, ins(1'b0, {MRI_GRP_LOAD, 1'b0}, 1'b1, 10'h100));
    mm(15'h0401, ins(1'b0, MRI_OP_AND, 1'b0, 10'h020));
    mm(15'h0402, ins(1'b0, MRI_OP_XOR, 1'b1, 10'h101));
    mm(15'h0403, ins(1'b0, MRI_OP_IOR, 1'b0, 10'h021));
    mm(15'h0404, ins(1'b0, {MRI_GRP_STORE, 1'b0}, 1'b1, 10'h102));
    mm(15'h0405, ins(1'b0, {MRI_GRP_LOAD, 1'b1}, 1'b0, 10'h000));
    mm(15'h0406, ins(1'b0, MRI_OP_JMP, 1'b1, 10'h006));
    run_prog(15'h0400, 15'h0406);
    reg_read(MRI_REG_ACC_A);
    chk("acc a", rd_val, 16'hFCFB);
    reg_read(MRI_REG_ACC_B);
    chk("acc b", rd_val, 16'hFCFB);
    chk("stored", mri_mem_model_inst.mem[15'h0502], 16'hFCFB);
    chk("and operand", mri_mem_model_inst.mem[15'h0020], 16'h0F0F);
    chk("xor operand", mri_mem_model_inst.mem[15'h0501], 16'hFFFF);
    reg_read(3'h5);
    chk("unmapped", rd_val, 16'h0000);
    $display("test logic done");
  endtask : test_logic
  // Skips, adds with flags, subroutine jump and indirect chains
  task automatic test_arith();
    mm(15'h0900, 16'h7FFF);
    mm(15'h0901, 16'hFFFF);
    mm(15'h0902, 16'h0005);
    mm(15'h0023, 16'h1234);
    mm(15'h0024, 16'h8025);
    mm(15'h0025, 16'h080D);
    mm(15'h0800, ins(1'b0, {MRI_GRP_LOAD, 1'b1}, 1'b1, 10'h101));
    mm(15'h0801, ins(1'b0, MRI_OP_ISZ, 1'b0, 10'h001));
    mm(15'h0802, ins(1'b0, {MRI_GRP_LOAD, 1'b0}, 1'b0, 10'h023));
    mm(15'h0803, ins(1'b0, MRI_OP_ISZ, 1'b1, 10'h102));
    mm(15'h0804, ins(1'b0, {MRI_GRP_LOAD, 1'b0}, 1'b1, 10'h100));
    mm(15'h0805, ins(1'b0, {MRI_GRP_ADD, 1'b0}, 1'b0, 10'h021));
    mm(15'h0806, ins(1'b0, {MRI_GRP_LOAD, 1'b1}, 1'b1, 10'h101));
    mm(15'h0807, ins(1'b0, {MRI_GRP_ADD, 1'b1}, 1'b0, 10'h021));
    mm(15'h0808, ins(1'b0, {MRI_GRP_CMP, 1'b0}, 1'b0, 10'h001));
    mm(15'h0809, ins(1'b0, {MRI_GRP_LOAD, 1'b0}, 1'b0, 10'h023));
    mm(15'h080A, ins(1'b0, {MRI_GRP_CMP, 1'b1}, 1'b0, 10'h001));
    mm(15'h080B, ins(1'b0, MRI_OP_JSB, 1'b1, 10'h110));
    mm(15'h0911, ins(1'b1, MRI_OP_JMP, 1'b1, 10'h110));
    mm(15'h080C, ins(1'b1, MRI_OP_JMP, 1'b0, 10'h024));
    mm(15'h080D, ins(1'b0, MRI_OP_JMP, 1'b1, 10'h00D));
    run_prog(15'h0800, 15'h080D);
    reg_read(MRI_REG_ACC_A);
    chk("sum a", rd_val, 16'h8000);
    reg_read(MRI_REG_ACC_B);
    chk("sum b", rd_val, 16'h0000);
    reg_read(MRI_REG_STATUS);
    chk("flags", {14'h0000, rd_val[1:0]}, 16'h0003);
    chk("add operand", mri_mem_model_inst.mem[15'h0021], 16'h0001);
    chk("incremented", mri_mem_model_inst.mem[15'h0902], 16'h0006);
    chk("return word", mri_mem_model_inst.mem[15'h0910], 16'h080C);
    $display("test arith done");
  endtask : test_arith
  // Increment-skip on an accumulator wraps to zero without flags
  task automatic test_isz_acc();
    mm(15'h0C00, ins(1'b0, MRI_OP_ISZ, 1'b0, 10'h000));
    mm(15'h0C01, ins(1'b0, MRI_OP_JMP, 1'b1, 10'h001));
    mm(15'h0C02, ins(1'b0, MRI_OP_JMP, 1'b1, 10'h002));
    reg_write(MRI_REG_ACC_A, 16'hFFFF);
    run_prog(15'h0C00, 15'h0C02);
    reg_read(MRI_REG_ACC_A);
    chk("wrapped a", rd_val, 16'h0000);
    reg_read(MRI_REG_STATUS);
    chk("flags kept", {14'h0000, rd_val[1:0]}, 16'h0000);
    $display("test isz done");
  endtask : test_isz_acc
  // ------------------------------------------------------------
  // Verdict and run control
  // ------------------------------------------------------------
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk_i);
    error_cnt++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    test_logic();
    test_arith();
    test_isz_acc();
    close_out();
  end
endmodule : memory_reference_instruction_unit_test
`default_nettype wire
